// ---- hw/reloc_pkg.sv ----
// constants, types and carriers for the storage address relocation block
package reloc_pkg;

   // =====================================================================
   // address geometry
   localparam int ADDR_W      = 24;
   localparam int WORD_ADDR_W = 22;
   localparam int DISP_W      = 12;
   localparam int OFS_W       = 12;
   localparam int FLAG_W      = 5;
   localparam int KEY_W       = 4;
   localparam int BYTE_SEL_W  = 2;
   localparam int OFS_LSB     = 8;
   localparam int OFS_MSB     = 19;
   localparam int PAR_LO_MSB  = 8;
   localparam int PAR_MID_MSB = 17;

   // relocation table in low storage, one word per key
   localparam logic [ADDR_W-1:0] RELOC_TABLE_BASE = 24'h000140;

   // relocation word layout (bit 0 of the word is the leftmost data bit)
   localparam int RW_FLAG_MSB = 28;
   localparam int RW_FLAG_LSB = 24;
   localparam int RW_OFS_MSB  = 23;
   localparam int RW_OFS_LSB  = 12;

   // flag positions inside the 5-bit flags field
   localparam int FLAG_RI = 4;
   localparam int FLAG_ID = 3;
   localparam int FLAG_RD = 2;
   localparam int FLAG_IO = 1;
   localparam int FLAG_RO = 0;
   localparam logic [FLAG_W-1:0] LBR_FLAGS   = 5'h15;
   localparam logic [FLAG_W-1:0] FLAGS_CLEAR = 5'h00;
   localparam logic [FLAG_W-1:0] REL_MASK    = 5'h15;

   // byte-write lines; line 0 is the leftmost byte, data[31:24]
   localparam logic [3:0] BW_NONE  = 4'h0;
   localparam logic [3:0] BW_BYTE0 = 4'h1;

   // register map on the APB slave
   localparam int APB_ADDR_W = 12;
   localparam logic [APB_ADDR_W-1:0] REG_CTRL      = 12'h000;
   localparam logic [APB_ADDR_W-1:0] REG_CRR       = 12'h004;
   localparam logic [APB_ADDR_W-1:0] REG_STATUS    = 12'h008;
   localparam logic [APB_ADDR_W-1:0] REG_LAST_ADDR = 12'h00C;
   localparam int CTRL_CLEAR  = 0;
   localparam int ST_BUSY     = 0;
   localparam int ST_ADDR_EXC = 1;
   localparam int ST_SPEC_EXC = 2;

   // =====================================================================
   // request types
   typedef enum logic [2:0] {
      OP_ACCESS,
      OP_LOAD_KEY,
      OP_BRANCH_LINK_EXT,
      OP_BRANCH_RET_EXT,
      OP_LOAD_BASE_REL
   } op_t;

   typedef enum logic [2:0] {
      K_INSTR,
      K_BRANCH,
      K_DEST,
      K_ORIGIN,
      K_INDIRECT_CONTROL_WORD,
      K_ABS
   } kind_t;

   typedef enum logic {
      SRC_PROC,
      SRC_IO
   } src_t;

   typedef struct packed {
      op_t               op;
      src_t              src;
      kind_t             kind;
      logic              rx_fmt;
      logic              indirect_control_word_rel;
      logic [KEY_W-1:0]  key;
      logic [ADDR_W-1:0] base;
      logic [ADDR_W-1:0] index;
      logic [DISP_W-1:0] disp;
      logic [FLAG_W-1:0] new_flags;
      logic [3:0]        byte_wr;
      logic [31:0]       wdata;
   } req_t;

   typedef struct packed {
      logic [31:0]           rdata;
      logic [BYTE_SEL_W-1:0] byte_ofs;
      logic [ADDR_W-1:0]     abs_addr;
      logic                  addr_exc;
      logic                  spec_exc;
   } resp_t;

   typedef struct packed {
      logic [WORD_ADDR_W-1:0] word_addr;
      logic [3:0]             byte_wr;
      logic [2:0]             parity;
      logic [31:0]            wdata;
   } st_req_t;

endpackage

// ---- hw/storage_address_relocation.sv ----
// storage address formation, relocation and word-address storage port
//
// Behaviour
// - byte addresses are 24 bits; only low 20 reach real storage
// - drop two low byte bits, send a 22-bit word address
// - word is named by its leftmost byte; offset zero is leftmost
// - four byte-write lines, one per byte; all four write the word
// - no byte-write line asserted means a read of the word
// - three parity bits: low nine, next nine, top four plus controls
// - reads return four bytes; requester picks byte by low two bits
// - address arithmetic wraps at 16,777,215 to zero silently
// - relative address is displacement plus base, plus index for RX
// - relocation adds 12-bit offset to address bits 8..19 only
// - relocation moves programs on 256-byte boundaries
// - sixteen relocation words at 140h..17Fh, one per key
// - processor and channel use their own key to pick the word
// - current copy reloads on status word load or interrupt init
// - flag-changing instructions write the new flags back to low storage
// - clear state holds the current relocation copy at zero
// - hardware, trace and subchannel addresses are never relocated
// - processor address whose relative flag is zero passes unchanged
// - instruction, operand, branch and channel addresses relocate
// - channel relocation ignores flags, adds the offset to every kind except the absolute (K_ABS) addresses
// - offset comes from bits 8..19 of the selected relocation word
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps

module storage_address_relocation (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,

   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [reloc_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,

   // requester side (processor or channel)
   input  wire logic                         req_valid,
   input  wire reloc_pkg::req_t              req,
   output logic                              req_ready,
   output logic                              resp_valid,
   output reloc_pkg::resp_t                  resp,
   input  wire logic                         clear_state,

   // main storage port
   output logic                              st_valid,
   output reloc_pkg::st_req_t                st,
   input  wire logic                         st_ack,
   input  wire logic [31:0]                  st_rdata,
   input  wire logic                         st_addr_exc
);
   import reloc_pkg::*;


   // ======================================================================
   // helpers
   function automatic logic [ADDR_W-1:0] relocate(input logic [ADDR_W-1:0] a,
                                                  input logic [OFS_W-1:0]  ofs);
      logic [OFS_W-1:0] hi;
      hi = a[OFS_MSB:OFS_LSB] + ofs;
      return {a[ADDR_W-1:OFS_MSB+1], hi, a[OFS_LSB-1:0]};
   endfunction


   function automatic logic [2:0] req_parity(input logic [WORD_ADDR_W-1:0] wa,
                                             input logic [3:0]             bw);
      logic [2:0] p;
      p[0] = ~^wa[PAR_LO_MSB:0];
      p[1] = ~^wa[PAR_MID_MSB:PAR_LO_MSB+1];
      p[2] = ~^{wa[WORD_ADDR_W-1:PAR_MID_MSB+1], bw};
      return p;
   endfunction


   function automatic logic [ADDR_W-1:0] table_addr(input logic [KEY_W-1:0] k);
      return RELOC_TABLE_BASE + {18'h0, k, 2'h0};
   endfunction


   // ======================================================================
   // state
   typedef enum logic [2:0] {S_IDLE, S_FETCH, S_ACCESS, S_WRBACK, S_DONE} state_t;


   state_t              state_r;

   req_t                req_r;

   logic [FLAG_W-1:0]   crr_flags_r;
   logic [OFS_W-1:0]    crr_ofs_r;
   logic [KEY_W-1:0]    crr_key_r;

   logic [OFS_W-1:0]    io_ofs_r;

   logic [ADDR_W-1:0]   rel_addr_r;

   logic [ADDR_W-1:0]   last_addr_r;

   logic                ctrl_clear_r;

   logic                addr_exc_r;
   logic                spec_exc_r;

   logic                clear_now;

   logic [ADDR_W-1:0]   rel_addr;

   logic                proc_rel;

   logic                spec_bad;

   assign clear_now = clear_state | ctrl_clear_r;

   assign req_ready = (state_r == S_IDLE);

   // relative address, 24-bit wrap by truncation
   always_comb begin
      rel_addr = req.base + {{(ADDR_W-DISP_W){1'b0}}, req.disp};
      if (req.rx_fmt) begin
         rel_addr = rel_addr + req.index;
      end
   end

   // processor relocation decision from the current flags, or the request's own bit for indirect control words
   always_comb begin
      case (req_r.kind)
         K_INSTR, K_BRANCH: proc_rel = crr_flags_r[FLAG_RI];
         K_DEST:   proc_rel = crr_flags_r[FLAG_RD];
         K_ORIGIN: proc_rel = crr_flags_r[FLAG_RO];
         K_INDIRECT_CONTROL_WORD:   proc_rel = req_r.indirect_control_word_rel;
         K_ABS:    proc_rel = 1'b0;
         default:  proc_rel = 1'b0;
      endcase
   end

   // return-external with all relative flags zero while RI is set is refused
   assign spec_bad = (req.op == OP_BRANCH_RET_EXT) && crr_flags_r[FLAG_RI] &&
                     ((req.new_flags & REL_MASK) == FLAGS_CLEAR);

   // ======================================================================
   // sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= S_IDLE;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (req_valid) begin
                  case (req.op)
                     OP_ACCESS:
                        state_r <= (req.src == SRC_IO && req.kind != K_ABS) ?
                                   S_FETCH : S_ACCESS;
                     OP_LOAD_KEY:        state_r <= S_FETCH;
                     OP_BRANCH_RET_EXT:  state_r <= spec_bad ? S_DONE : S_WRBACK;
                     OP_BRANCH_LINK_EXT: state_r <= S_WRBACK;
                     OP_LOAD_BASE_REL:   state_r <= S_WRBACK;
                     default:            state_r <= S_DONE;
                  endcase
               end
            end
            S_FETCH: begin
               if (st_ack) begin
                  state_r <= (req_r.op == OP_ACCESS) ? S_ACCESS : S_DONE;
               end
            end
            S_ACCESS: begin
               if (st_ack) begin
                  state_r <= S_DONE;
               end
            end
            S_WRBACK: begin
               if (st_ack) begin
                  state_r <= S_DONE;
               end
            end
            S_DONE:  state_r <= S_IDLE;
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // captured request and its relative address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_r      <= '0;
         rel_addr_r <= '0;
      end else if (state_r == S_IDLE && req_valid) begin
         req_r      <= req;
         rel_addr_r <= rel_addr;
      end
   end

   // channel offset fetched from the key's relocation word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_ofs_r <= '0;
      end else if (state_r == S_FETCH && st_ack) begin
         io_ofs_r <= st_rdata[RW_OFS_MSB:RW_OFS_LSB];
      end
   end

   // current relocation register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crr_flags_r <= FLAGS_CLEAR;
         crr_ofs_r   <= '0;
         crr_key_r   <= '0;
      end else if (clear_now) begin
         crr_flags_r <= FLAGS_CLEAR;
         crr_ofs_r   <= '0;
         crr_key_r   <= '0;
      end else if (state_r == S_FETCH && st_ack && req_r.op == OP_LOAD_KEY) begin
         crr_flags_r <= st_rdata[RW_FLAG_MSB:RW_FLAG_LSB];
         crr_ofs_r   <= st_rdata[RW_OFS_MSB:RW_OFS_LSB];
         crr_key_r   <= req_r.key;
      end else if (state_r == S_IDLE && req_valid) begin
         case (req.op)
            OP_BRANCH_RET_EXT: begin
               if (!spec_bad) begin
                  crr_flags_r <= req.new_flags;
               end
            end
            OP_BRANCH_LINK_EXT: crr_flags_r[FLAG_RI] <= req.new_flags[FLAG_RI];
            OP_LOAD_BASE_REL:   crr_flags_r <= LBR_FLAGS;
            default:            ;
         endcase
      end
   end

   // ======================================================================
   // storage port: request held until acknowledged
   logic [ADDR_W-1:0] abs_addr;
   logic [ADDR_W-1:0] st_byte_addr;

   logic [3:0]        st_bw;
   logic [31:0]       st_wd;

   always_comb begin
      if (req_r.src == SRC_IO) begin
         abs_addr = (req_r.kind == K_ABS) ? rel_addr_r :
                    relocate(rel_addr_r, io_ofs_r);
      end else begin
         abs_addr = proc_rel ? relocate(rel_addr_r, crr_ofs_r) :
                    rel_addr_r;
      end
   end

   always_comb begin
      st_byte_addr = abs_addr;
      st_bw        = BW_NONE;
      st_wd        = '0;
      case (state_r)
         S_FETCH: begin
            st_byte_addr = table_addr(req_r.key);
         end
         S_ACCESS: begin
            st_bw = req_r.byte_wr;
            st_wd = req_r.wdata;
         end
         S_WRBACK: begin
            // bits 0-2 return as zero; other lanes untouched
            st_byte_addr = table_addr(crr_key_r);
            st_bw        = BW_BYTE0;
            st_wd        = {3'h0, crr_flags_r, 24'h000000};
         end
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_valid <= 1'b0;
         st       <= '0;
      end else if (st_valid && st_ack) begin
         st_valid <= 1'b0;
      end else if (!st_valid && (state_r == S_FETCH || state_r == S_ACCESS ||
                                 state_r == S_WRBACK)) begin
         st_valid     <= 1'b1;
         st.word_addr <= st_byte_addr[ADDR_W-1:BYTE_SEL_W];
         st.byte_wr   <= st_bw;
         st.parity    <= req_parity(st_byte_addr[ADDR_W-1:BYTE_SEL_W], st_bw);
         st.wdata     <= st_wd;
      end
   end

   // ======================================================================
   // answer to the requester
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_valid <= 1'b0;
         resp       <= '0;
      end else begin
         resp_valid <= (state_r == S_DONE);
         if (state_r == S_ACCESS && st_ack) begin
            resp.rdata    <= st_rdata;
            resp.byte_ofs <= abs_addr[BYTE_SEL_W-1:0];
            resp.abs_addr <= abs_addr;
            resp.addr_exc <= st_addr_exc;
         end else if (state_r == S_IDLE && req_valid) begin
            resp          <= '0;
            resp.spec_exc <= spec_bad;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_addr_r <= '0;
         addr_exc_r  <= 1'b0;
         spec_exc_r  <= 1'b0;
      end else begin
         if (state_r == S_ACCESS && st_ack) begin
            last_addr_r <= abs_addr;
            addr_exc_r  <= st_addr_exc;
         end
         if (state_r == S_IDLE && req_valid) begin
            spec_exc_r <= spec_bad;
         end
      end
   end

   // ======================================================================
   // apb slave: data latched in setup, zero-wait access
   logic setup;
   logic mapped;
   logic [31:0] rd_mux;

   assign setup  = psel && !penable;

   assign pready = 1'b1;

   always_comb begin
      mapped = 1'b1;
      rd_mux = '0;
      case (paddr)
         REG_CTRL:      rd_mux[CTRL_CLEAR] = ctrl_clear_r;
         REG_CRR:       rd_mux = {3'h0, crr_flags_r, crr_ofs_r,
                                  8'h00, crr_key_r};
         REG_STATUS: begin
            rd_mux[ST_BUSY]     = (state_r != S_IDLE);
            rd_mux[ST_ADDR_EXC] = addr_exc_r;
            rd_mux[ST_SPEC_EXC] = spec_exc_r;
         end
         REG_LAST_ADDR: rd_mux = {8'h00, last_addr_r};
         default:       mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h00000000 : rd_mux;
         pslverr <= !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_clear_r <= 1'b0;
      end else if (psel && penable && pwrite && paddr == REG_CTRL) begin
         ctrl_clear_r <= pwdata[CTRL_CLEAR];
      end
   end

endmodule

// ---- bench/storage_address_relocation_sva.sv ----
// assertion checker for the storage address relocation block
`timescale 1ns/1ps

module storage_address_relocation_sva (
   // clock and reset
   input wire logic               pclk,
   input wire logic               presetn,
   // requester side
   input wire logic               req_valid,
   input wire reloc_pkg::req_t    req,
   input wire logic               req_ready,
   input wire logic               resp_valid,
   input wire reloc_pkg::resp_t   resp,
   input wire logic               clear_state,
   // storage port
   input wire logic               st_valid,
   input wire reloc_pkg::st_req_t st,
   input wire logic               st_ack,
   input wire logic [31:0]        st_rdata,
   input wire logic               st_addr_exc
);
   import reloc_pkg::*;
   // ==================================================================
   // last request and answer
   op_t         op_r;
   logic [3:0]  key_r;
   logic [21:0] wa_r;
   logic [31:0] rd_r;
   logic        exc_r;
   logic        rd_op_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_r <= OP_ACCESS;
      end else if (req_valid && req_ready) begin
         op_r <= req.op;
      end
   end
   // key of the last key load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_r <= 4'h0;
      end else if (clear_state) begin
         key_r <= 4'h0;
      end else if (req_valid && req_ready && req.op == OP_LOAD_KEY) begin
         key_r <= req.key;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wa_r <= '0;
         rd_r <= '0;
         exc_r <= 1'b0;
         rd_op_r <= 1'b0;
      end else if (st_valid && st_ack) begin
         wa_r <= st.word_addr;
         rd_r <= st_rdata;
         exc_r <= st_addr_exc;
         rd_op_r <= st.byte_wr == BW_NONE;
      end
   end
   // ==================================================================
   // properties
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_par_low: assert property (st_valid |-> st.parity[0] == ~^st.word_addr[8:0])
      else $error("low parity");
   chk_par_mid: assert property (st_valid |-> st.parity[1] == ~^st.word_addr[17:9])
      else $error("mid parity");
   chk_par_top: assert property (st_valid |->
      st.parity[2] == ~^{st.word_addr[21:18], st.byte_wr}) else $error("top parity wrong");
   chk_st_hold: assert property (st_valid && !st_ack |=> st_valid && $stable(st))
      else $error("request not held");
   chk_st_drop: assert property (st_valid && st_ack |=> !st_valid)
      else $error("request not dropped");
   chk_resp_addr: assert property (resp_valid && op_r == OP_ACCESS |->
      resp.abs_addr[23:2] == wa_r) else $error("word address");
   chk_resp_data: assert property (resp_valid && op_r == OP_ACCESS && rd_op_r |->
      resp.rdata == rd_r && resp.addr_exc == exc_r) else $error("read answer lost");
   chk_byte_ofs: assert property (resp_valid |-> resp.byte_ofs == resp.abs_addr[1:0])
      else $error("byte offset wrong");
   chk_proc_start: assert property (req_valid && req_ready && req.op == OP_ACCESS
      && req.src == SRC_PROC |-> ##2 st_valid) else $error("access not started");
   chk_table_addr: assert property (st_valid && op_r != OP_ACCESS |->
      st.word_addr == RELOC_TABLE_BASE[23:2] + 22'(key_r)) else $error("table word wrong");
   chk_wb_lanes: assert property (st_valid && op_r == OP_LOAD_BASE_REL |->
      st.byte_wr == BW_BYTE0 && st.wdata[31:29] == 3'b000) else $error("write-back lanes");
endmodule

bind storage_address_relocation storage_address_relocation_sva storage_address_relocation_sva_i (
   .pclk(pclk), .presetn(presetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .resp_valid(resp_valid), .resp(resp), .clear_state(clear_state), .st_valid(st_valid),
   .st(st), .st_ack(st_ack), .st_rdata(st_rdata), .st_addr_exc(st_addr_exc));

// ---- bench/storage_model.sv ----
// behavioural main storage array facing the relocation block
`timescale 1ns/1ps

module storage_model (
   // clock and reset
   input wire logic               pclk,
   input wire logic               presetn,
   // storage port
   input wire logic               st_valid,
   input wire reloc_pkg::st_req_t st,
   output logic                   st_ack,
   output logic [31:0]            st_rdata,
   output logic                   st_addr_exc,
   // pacing chosen by the bench
   input wire logic               slow
);
   import reloc_pkg::*;
   logic [31:0] mem [logic [21:0]];
   int          wait_r;
   // unwritten words read as their own word address, with its low ten bits repeated on top
   function automatic logic [31:0] peek(input logic [21:0] wa);
      return mem.exists(wa) ? mem[wa] : {wa[9:0], wa};
   endfunction
   always @(posedge pclk or negedge presetn) begin
      logic [31:0] w;
      w = peek(st.word_addr);
      if (!presetn) begin
         st_ack <= 1'b0;
         st_rdata <= '0;
         st_addr_exc <= 1'b0;
         wait_r <= 0;
      end else if (st_valid && !st_ack && wait_r == 0) begin
         st_ack <= 1'b1;
         st_addr_exc <= st.word_addr[21:18] != 4'h0;
         st_rdata <= w;
         for (int b = 0; b < 4; b++)
            if (st.byte_wr[b]) w[31-8*b -: 8] = st.wdata[31-8*b -: 8];
         if (st.byte_wr != BW_NONE && st.word_addr[21:18] == 4'h0) mem[st.word_addr] = w;
         wait_r <= slow ? $urandom_range(0, 6) : 0;
      end else begin
         // idle lines toggle: stale data is never trusted
         st_ack <= 1'b0;
         st_rdata <= ~st_rdata;
         st_addr_exc <= ~st_addr_exc;
         if (st_valid && !st_ack) wait_r <= wait_r - 1;
      end
   end
endmodule

// ---- bench/storage_address_relocation_tb_top.sv ----
// self-checking testbench for the storage address relocation block
`timescale 1ns/1ps

module storage_address_relocation_tb_top;
   import reloc_pkg::*;
   localparam logic [21:0] TBL = RELOC_TABLE_BASE[23:2];
   // ==================================================================
   // stimulus and observed signals
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        req_valid = 1'b0;
   req_t        req = '0;
   logic        req_ready;
   logic        resp_valid;
   resp_t       resp;
   logic        clear_state = 1'b0;
   logic        st_valid;
   st_req_t     st;
   logic        st_ack;
   logic [31:0] st_rdata;
   logic        st_addr_exc;
   logic        slow = 1'b0;
   logic [4:0]  cur_fl = '0;
   logic [11:0] cur_ofs = '0;
   logic [3:0]  cur_key = '0;
   int          errors = 0;
   int          checked = 0;
   always #2.5 pclk = ~pclk;
   storage_address_relocation storage_address_relocation_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .clear_state(clear_state),
      .st_valid(st_valid), .st(st), .st_ack(st_ack), .st_rdata(st_rdata),
      .st_addr_exc(st_addr_exc));
   storage_model storage_model_i (.pclk(pclk), .presetn(presetn), .st_valid(st_valid),
      .st(st), .st_ack(st_ack), .st_rdata(st_rdata), .st_addr_exc(st_addr_exc), .slow(slow));
   // ==================================================================
   // shared tasks and expectations
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, logic [11:0] a, logic [31:0] wd,
                      output logic [31:0] rd, logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!pready && n < 100);
      if (n >= 100) begin
         errors++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic send(input req_t r);
      int n;
      @(posedge pclk);
      req_valid <= 1'b1;
      req <= r;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (!req_ready && n < 400);
      req_valid <= 1'b0;
      while (!resp_valid && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 400) begin
         errors++;
         finish_test();
      end
   endtask
   task automatic crr_check;
      logic [31:0] d;
      logic        e;
      apb(1'b0, REG_CRR, 32'h0, d, e);
      check(d, {3'b000, cur_fl, cur_ofs, 8'h00, cur_key});
   endtask
   function automatic logic [23:0] exp_abs(input req_t r);
      logic [23:0] a;
      logic [11:0] io_ofs;
      logic        rel;
      a = r.base + 24'(r.disp) + (r.rx_fmt ? r.index : 24'h0);
      io_ofs = storage_model_i.peek(TBL + 22'(r.key)) >> 12;
      case (r.kind)
         K_INSTR, K_BRANCH: rel = cur_fl[FLAG_RI];
         K_DEST:            rel = cur_fl[FLAG_RD];
         K_ORIGIN:          rel = cur_fl[FLAG_RO];
         K_INDIRECT_CONTROL_WORD:            rel = r.indirect_control_word_rel;
         default:           rel = 1'b0;
      endcase
      if (r.src == SRC_IO)
         return (r.kind == K_ABS) ? a : {a[23:20], a[19:8] + io_ofs, a[7:0]};
      return rel ? {a[23:20], a[19:8] + cur_ofs, a[7:0]} : a;
   endfunction
   task automatic access(input req_t r);
      logic [23:0] a;
      logic [31:0] old, ex;
      logic        exc;
      a = exp_abs(r);
      exc = a[23:20] != 4'h0;
      old = storage_model_i.peek(a[23:2]);
      ex = old;
      for (int b = 0; b < 4; b++)
         if (r.byte_wr[b] && !exc) ex[31-8*b -: 8] = r.wdata[31-8*b -: 8];
      send(r);
      check(32'(resp.abs_addr), 32'(a));
      check(32'(resp.addr_exc), 32'(exc));
      check(32'(resp.byte_ofs), 32'(a[1:0]));
      if (r.byte_wr == BW_NONE) check(resp.rdata, old);
      check(storage_model_i.peek(a[23:2]), ex);
   endtask
   // ==================================================================
   // main sequence
   initial begin
      req_t        r;
      logic [31:0] d, w;
      logic [3:0]  k;
      logic        e;
      void'($urandom(32'h67EEFBCF));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      crr_check();
      apb(1'b0, 12'h010, 32'h0, d, e);
      check(32'(e), 32'h1);
      apb(1'b1, REG_CTRL, 32'h1, d, e);
      apb(1'b0, REG_CTRL, 32'h0, d, e);
      check(d, 32'h1);
      apb(1'b1, REG_CTRL, 32'h0, d, e);
      r = '0;
      r.kind = K_ABS;
      r.base = 24'hFFFFFF;
      r.disp = 12'h001;
      access(r);
      for (int i = 0; i < 8; i++) begin
         w = $urandom;
         k = 4'($urandom);
         storage_model_i.mem[TBL + 22'(k)] = w;
         r = '0;
         r.op = OP_LOAD_KEY;
         r.key = k;
         send(r);
         {cur_fl, cur_ofs, cur_key} = {w[28:12], k};
         crr_check();
         if (i == 4) begin
            r.op = OP_LOAD_BASE_REL;
            send(r);
            cur_fl = LBR_FLAGS;
            crr_check();
            check(storage_model_i.peek(TBL + 22'(k)), {3'b000, LBR_FLAGS, w[23:0]});
            r.op = OP_BRANCH_RET_EXT;
            send(r);
            check(32'(resp.spec_exc), 32'h1);
         end
         for (int j = 0; j < 12; j++) begin
            r = '0;
            r.src = src_t'($urandom_range(0, 1));
            r.kind = kind_t'(j % 6);
            r.rx_fmt = 1'($urandom);
            r.indirect_control_word_rel = 1'($urandom);
            r.key = (r.src == SRC_IO) ? 4'($urandom) : k;
            r.base = (j == 11) ? 24'($urandom) : 24'($urandom) & 24'h0FFFFF;
            r.index = 24'($urandom) & 24'h00FFFF;
            r.disp = (j == 0) ? 12'hFFF : 12'($urandom);
            r.byte_wr = ($urandom_range(0, 2) == 0) ? BW_NONE : 4'($urandom);
            r.wdata = $urandom;
            access(r);
         end
         slow <= ~slow;
      end
      // clear state wipes a loaded copy
      clear_state <= 1'b1;
      repeat (2) @(posedge pclk);
      clear_state <= 1'b0;
      {cur_fl, cur_ofs, cur_key} = '0;
      crr_check();
      finish_test();
   end
endmodule
